// ### include/ocd_regs.svh
// Offsets, field positions, reset values and timing counts of the option byte decoder.
// Function
// - Option bytes never appear in processor address map.
// - Erased store bytes read as FFh.
// - Byte0 bit7 set: halt entry resets while the watchdog is active.
// - Byte0 bit6 clear: watchdog always on outside reset.
// - Byte0 bit5 clear enables clock guard.
// - Byte0 bits4:3 pick supply detector threshold.
// - Read-out lock blocks store access in programming.
// - Locked option erase wipes user memory first.
// - Byte1 bit7, byte0 bit1 select package.
// - Unbonded pads stay pulled-up inputs after reset.
// - Byte1 bit6 picks 4096 or 256 cycles.
// - Byte1 bits5:4 select main clock source.
// - Byte1 bits3:1 select frequency range.
// - Byte1 bit0 clear enables clock doubler.
// - Blank parts ship with internal RC selected.
// - Masked parts have fixed, unprogrammable options.
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH

// Register byte offsets on the APB.
`define OCD_CTRL_OFFSET    12'h000
`define OCD_STATUS_OFFSET  12'h004
`define OCD_COUNT_OFFSET   12'h008

// Control and status field positions.
`define OCD_CTRL_WDG_EN    0
`define OCD_ST_RUN         0
`define OCD_ST_LOCKED      1
`define OCD_ST_PKG64       2
`define OCD_ST_WARN_PLL    3
`define OCD_ST_WARN_LOCK   4
`define OCD_ST_WARN_RST    5
`define OCD_ST_MASKED      6

// Option byte 0 field positions.
`define OCD_B0_HALT        7
`define OCD_B0_WDGSW       6
`define OCD_B0_GUARD       5
`define OCD_B0_VD_HI       4
`define OCD_B0_VD_LO       3
`define OCD_B0_PKG         1
`define OCD_B0_LOCK        0

// Option byte 1 field positions.
`define OCD_B1_PKG         7
`define OCD_B1_RESET_DELAY_SEL        6
`define OCD_B1_SRC_HI      5
`define OCD_B1_SRC_LO      4
`define OCD_B1_RNG_HI      3
`define OCD_B1_RNG_LO      1
`define OCD_B1_PLL         0

// Reset values: erased content and shipped blank content.
`define OCD_ERASED_BYTE    8'hFF
`define OCD_SHIP_BYTE0     8'hE7
`define OCD_SHIP_BYTE1     8'hEF
`define OCD_VD_OFF         2'h3
`define OCD_RANGE_MP       3'h1

// Reset and halt exit phase lengths in CPU cycles.
`define OCD_RST_LONG_CYC   4096
`define OCD_RST_SHORT_CYC  256

`endif

// ### include/ocd_pkg.sv
// Types shared by the option byte decoder modules.
package ocd_pkg;

  // Main clock source encodings.
  typedef enum logic [1:0] {
    OCD_SRC_RESONATOR = 2'h0,
    OCD_SRC_RESERVED  = 2'h1,
    OCD_SRC_RC        = 2'h2,
    OCD_SRC_EXT       = 2'h3
  } ocd_src_t;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    OCD_CAPTURE = 5'h01,
    OCD_DELAY   = 5'h02,
    OCD_RUN     = 5'h04,
    OCD_HALT    = 5'h08,
    OCD_WAKE    = 5'h10
  } ocd_state_t;

  // Decoded hardware configuration.
  typedef struct packed {
    logic       halt_entry_reset_sel;
    logic       watchdog_type_sel;
    logic       clock_guard_disable;
    logic [1:0] supply_detect_level;
    logic       low_supply_reset_detector;
    logic       supply_warning_detector;
    logic       readout_lock_n;
    logic       pkg_64pin;
    logic       reset_delay_sel;
    ocd_src_t   clock_source_sel;
    logic [2:0] clock_freq_range;
    logic       doubler_disable;
  } ocd_cfg_t;

  // Request from the in-circuit programming logic.
  typedef struct packed {
    logic       mode;
    logic       we;
    logic       addr;
    logic [7:0] wdata;
    logic       erase;
  } ocd_prog_req_t;

  // State of the option byte store.
  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] rdata;
    logic       erasing;
  } ocd_store_t;

  // State of the decoder top.
  typedef struct packed {
    ocd_state_t  state;
    logic [15:0] cnt;
    ocd_cfg_t    cfg;
    logic        watchdog_type_sel_en;
    logic        access_en;
    logic [31:0] prdata;
    logic        pslverr;
  } ocd_top_t;

endpackage

// ### core/ocd_nv_store.sv
// Option byte store reached only through the programming port.
`timescale 1ns/1ns
`include "ocd_regs.svh"
module ocd_nv_store
  import ocd_pkg::*;
#(
  parameter bit         MASKED     = 1'b0,
  parameter logic [7:0] MASK_BYTE0 = `OCD_SHIP_BYTE0,
  parameter logic [7:0] MASK_BYTE1 = `OCD_SHIP_BYTE1
) (
  input  wire logic          pclk,
  input  wire logic          store_init_n,
  input  wire ocd_prog_req_t prog_req,
  input  wire logic          mem_erase_done,
  output logic [7:0]         prog_rdata,
  output logic               mem_erase_req,
  output logic [7:0]         opt_byte0,
  output logic [7:0]         opt_byte1
);

  ocd_store_t s_reg;
  ocd_store_t s_next;

  // Programming accesses; nothing here is visible on the processor bus.
  always_comb begin
    s_next = s_reg;
    if (prog_req.mode) begin
      s_next.rdata = prog_req.addr ? s_reg.byte1 : s_reg.byte0;
    end else begin
      s_next.rdata = 8'h00;
    end
    if (s_reg.erasing) begin
      // The user memory must be gone before the lock can be lifted.
      if (mem_erase_done) begin
        s_next.byte0   = `OCD_ERASED_BYTE;
        s_next.byte1   = `OCD_ERASED_BYTE;
        s_next.erasing = 1'b0;
      end
    end else if (prog_req.mode && prog_req.erase) begin
      if (!s_reg.byte0[`OCD_B0_LOCK]) begin
        s_next.erasing = 1'b1;
      end else begin
        s_next.byte0 = `OCD_ERASED_BYTE;
        s_next.byte1 = `OCD_ERASED_BYTE;
      end
    end else if (prog_req.mode && prog_req.we) begin
      if (prog_req.addr) begin
        s_next.byte1 = prog_req.wdata;
      end else begin
        s_next.byte0 = prog_req.wdata;
      end
    end
    // Masked parts carry the code's values and ignore the programmer.
    if (MASKED) begin
      s_next.byte0   = MASK_BYTE0;
      s_next.byte1   = MASK_BYTE1;
      s_next.erasing = 1'b0;
    end
  end

  // The store initialises only with the array, never with the system reset.
  always_ff @(posedge pclk or negedge store_init_n) begin
    if (!store_init_n) begin
      s_reg <= {MASKED ? MASK_BYTE0 : `OCD_SHIP_BYTE0,
                MASKED ? MASK_BYTE1 : `OCD_SHIP_BYTE1, 8'h00, 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign prog_rdata    = s_reg.rdata;
  assign mem_erase_req = s_reg.erasing;
  assign opt_byte0     = s_reg.byte0;
  assign opt_byte1     = s_reg.byte1;

  a_erase_holds: assert property (@(posedge pclk) disable iff (!store_init_n)
    (s_reg.erasing && !mem_erase_done) |=> $stable({s_reg.byte0, s_reg.byte1}))
    else $error("option bytes changed before user memory erase finished");

  a_masked_fixed: assert property (@(posedge pclk) disable iff (!store_init_n)
    MASKED |-> (s_reg.byte0 == MASK_BYTE0 && s_reg.byte1 == MASK_BYTE1))
    else $error("masked option bytes were altered");

endmodule

// ### core/ocd_top.sv
// Option byte decoder: captures the option bytes in reset and drives the configuration.
`timescale 1ns/1ns
`include "ocd_regs.svh"
module ocd_top
  import ocd_pkg::*;
#(
  parameter int                RST_LONG_CYC    = `OCD_RST_LONG_CYC,
  parameter int                RST_SHORT_CYC   = `OCD_RST_SHORT_CYC,
  parameter int                NUM_PORTS       = 6,
  parameter logic [47:0]       UNBONDED44_MASK = 48'hFF00_F0F0_0F00,
  parameter bit                MASKED          = 1'b0,
  parameter logic [7:0]        MASK_BYTE0      = `OCD_SHIP_BYTE0,
  parameter logic [7:0]        MASK_BYTE1      = `OCD_SHIP_BYTE1
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            store_init_n,
  input  wire logic [11:0]     paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire ocd_prog_req_t   prog_req,
  input  wire logic            test_mode,
  input  wire logic            mem_erase_done,
  output logic [7:0]           prog_rdata,
  output logic                 mem_erase_req,
  input  wire logic            halt_enter,
  input  wire logic            halt_wake,
  output logic                 cpu_reset_n,
  output logic                 cpu_run,
  output ocd_cfg_t             cfg,
  output logic                 watchdog_enable,
  output logic                 user_store_access_en,
  output logic [NUM_PORTS*8-1:0] unbonded_pullup
);

  ocd_top_t   s_reg;
  ocd_top_t   s_next;
  logic [7:0] opt_byte0;
  logic [7:0] opt_byte1;
  logic       wdg_active;
  logic       warn_pll;
  logic       warn_lock;
  logic       warn_rst;
  logic       setup;
  logic       access;

  // Option byte store; the processor bus has no path into it.
  ocd_nv_store #(
    .MASKED        (MASKED),
    .MASK_BYTE0    (MASK_BYTE0),
    .MASK_BYTE1    (MASK_BYTE1)
  ) u_store (
    .pclk          (pclk),
    .store_init_n  (store_init_n),
    .prog_req      (prog_req),
    .mem_erase_done(mem_erase_done),
    .prog_rdata    (prog_rdata),
    .mem_erase_req (mem_erase_req),
    .opt_byte0     (opt_byte0),
    .opt_byte1     (opt_byte1)
  );

  // Turns the two raw bytes into the configuration the chip runs with.
  function automatic ocd_cfg_t ocd_decode(input logic [7:0] b0, input logic [7:0] b1);
    ocd_cfg_t   c;
    logic [1:0] src;
    src                    = b1[`OCD_B1_SRC_HI:`OCD_B1_SRC_LO];
    c.halt_entry_reset_sel = b0[`OCD_B0_HALT];
    c.watchdog_type_sel    = b0[`OCD_B0_WDGSW];
    c.clock_guard_disable  = b0[`OCD_B0_GUARD];
    c.supply_detect_level  = b0[`OCD_B0_VD_HI:`OCD_B0_VD_LO];
    c.low_supply_reset_detector = (c.supply_detect_level != `OCD_VD_OFF);
    c.supply_warning_detector   = (c.supply_detect_level != `OCD_VD_OFF);
    c.readout_lock_n       = b0[`OCD_B0_LOCK];
    // Only 00 means the small package; the other codes keep all pads bonded.
    c.pkg_64pin            = ({b1[`OCD_B1_PKG], b0[`OCD_B0_PKG]} != 2'h0);
    c.reset_delay_sel      = b1[`OCD_B1_RESET_DELAY_SEL];
    // The reserved code falls back to the RC oscillator, which needs no board parts.
    c.clock_source_sel     = (src == 2'h1) ? OCD_SRC_RC : ocd_src_t'(src);
    c.clock_freq_range     = b1[`OCD_B1_RNG_HI:`OCD_B1_RNG_LO];
    c.doubler_disable      = b1[`OCD_B1_PLL];
    return c;
  endfunction

  // Phase length picked by the captured configuration.
  function automatic logic [15:0] ocd_load(input logic short_sel);
    return short_sel ? 16'(RST_SHORT_CYC - 1) : 16'(RST_LONG_CYC - 1);
  endfunction

  // Settings the device tolerates but does not guarantee, flagged for software.
  assign warn_pll  = !s_reg.cfg.doubler_disable &&
                     (s_reg.cfg.clock_source_sel == OCD_SRC_RC ||
                      s_reg.cfg.clock_freq_range != `OCD_RANGE_MP);
  assign warn_lock = !s_reg.cfg.readout_lock_n &&
                     s_reg.cfg.low_supply_reset_detector;
  assign warn_rst  = s_reg.cfg.reset_delay_sel &&
                     s_reg.cfg.clock_source_sel == OCD_SRC_RESONATOR;

  // A software watchdog needs the enable bit; a hardware one is always on.
  assign wdg_active = !s_reg.cfg.watchdog_type_sel || s_reg.watchdog_type_sel_en;
  assign setup      = psel && !penable;
  assign access     = psel && penable;

  // Sequencer, access guard and APB slave in one next-state process.
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.state)
      OCD_CAPTURE: begin
        // The only moment the configuration may change.
        s_next.cfg   = ocd_decode(opt_byte0, opt_byte1);
        s_next.cnt   = ocd_load(opt_byte1[`OCD_B1_RESET_DELAY_SEL]);
        s_next.state = OCD_DELAY;
      end
      OCD_DELAY: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.state = OCD_RUN;
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
      OCD_RUN: begin
        if (halt_enter) begin
          if (wdg_active && s_reg.cfg.halt_entry_reset_sel) begin
            s_next.state     = OCD_CAPTURE;
            s_next.watchdog_type_sel_en = 1'b0;
          end else begin
            s_next.state = OCD_HALT;
          end
        end
      end
      OCD_HALT: begin
        if (halt_wake) begin
          s_next.cnt   = ocd_load(s_reg.cfg.reset_delay_sel);
          s_next.state = OCD_WAKE;
        end
      end
      OCD_WAKE: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.state = OCD_RUN;
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
      default: begin
        s_next.state = OCD_CAPTURE;
      end
    endcase

    // The lock follows the live store so a fresh lock bites without a reset.
    s_next.access_en = opt_byte0[`OCD_B0_LOCK] ||
                       !(prog_req.mode || test_mode);

    // Read data and error are prepared in the setup cycle and held for the access.
    if (setup) begin
      s_next.prdata  = 32'h0000_0000;
      s_next.pslverr = 1'b0;
      unique case (paddr)
        `OCD_CTRL_OFFSET: begin
          s_next.prdata[`OCD_CTRL_WDG_EN] = s_reg.watchdog_type_sel_en;
        end
        `OCD_STATUS_OFFSET: begin
          s_next.prdata[`OCD_ST_RUN]       = (s_reg.state == OCD_RUN);
          s_next.prdata[`OCD_ST_LOCKED]    = !s_reg.cfg.readout_lock_n;
          s_next.prdata[`OCD_ST_PKG64]     = s_reg.cfg.pkg_64pin;
          s_next.prdata[`OCD_ST_WARN_PLL]  = warn_pll;
          s_next.prdata[`OCD_ST_WARN_LOCK] = warn_lock;
          s_next.prdata[`OCD_ST_WARN_RST]  = warn_rst;
          s_next.prdata[`OCD_ST_MASKED]    = MASKED;
        end
        `OCD_COUNT_OFFSET: begin
          s_next.prdata[15:0] = s_reg.cnt;
        end
        default: begin
          // Option bytes have no address here; anything else is an error.
          s_next.pslverr = 1'b1;
        end
      endcase
    end

    // Writes land at the access edge; a reset in flight keeps the enable cleared.
    if (access && pwrite && paddr == `OCD_CTRL_OFFSET &&
        s_reg.state != OCD_CAPTURE && s_next.state != OCD_CAPTURE) begin
      s_next.watchdog_type_sel_en = pwdata[`OCD_CTRL_WDG_EN];
    end
  end

  // The reset value puts the sequencer in capture with the pads safe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{state: OCD_CAPTURE, cnt: 16'h0000, cfg: '0, watchdog_type_sel_en: 1'b0,
                 access_en: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Bus answers in the first access cycle; no wait states are ever inserted.
  assign pready               = 1'b1;
  assign prdata               = s_reg.prdata;
  assign pslverr              = s_reg.pslverr;
  assign cfg                  = s_reg.cfg;
  assign cpu_reset_n          = !(s_reg.state inside {OCD_CAPTURE, OCD_DELAY});
  assign cpu_run              = (s_reg.state == OCD_RUN);
  assign watchdog_enable      = cpu_reset_n && wdg_active;
  assign user_store_access_en = s_reg.access_en;

  // Pads without a package pin stay pulled-up inputs; the mask is per port.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_pad
    assign unbonded_pullup[p*8 +: 8] = (s_reg.cfg.pkg_64pin && cpu_reset_n) ?
                                       8'h00 : UNBONDED44_MASK[p*8 +: 8];
  end

  // Helper for the checks: cycles spent in the current delay phase.
  logic [15:0] dly_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_seen <= 16'h0000;
    end else if (s_reg.state inside {OCD_DELAY, OCD_WAKE}) begin
      dly_seen <= dly_seen + 16'h0001;
    end else begin
      dly_seen <= 16'h0000;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_capture_decode: assert property (
    s_reg.state == OCD_CAPTURE |=>
      s_reg.state == OCD_DELAY && s_reg.cfg == ocd_decode($past(opt_byte0), $past(opt_byte1)))
    else $error("configuration not captured from the option bytes");

  a_cfg_held: assert property (
    s_reg.state != OCD_CAPTURE |=> $stable(s_reg.cfg))
    else $error("configuration changed outside reset capture");

  a_delay_length: assert property (
    (s_reg.state inside {OCD_DELAY, OCD_WAKE}) && s_reg.cnt == 16'h0000 |->
      dly_seen == ocd_load(s_reg.cfg.reset_delay_sel) ##1 s_reg.state == OCD_RUN)
    else $error("reset or wake phase has the wrong length");

  a_halt_reset: assert property (
    s_reg.state == OCD_RUN && halt_enter && wdg_active && s_reg.cfg.halt_entry_reset_sel
      |=> !cpu_reset_n ##1 s_reg.state == OCD_DELAY)
    else $error("halt entry with active watchdog did not reset");

  a_halt_quiet: assert property (
    s_reg.state == OCD_RUN && halt_enter && !(wdg_active && s_reg.cfg.halt_entry_reset_sel)
      |=> s_reg.state == OCD_HALT && cpu_reset_n)
    else $error("halt entry reset when it should not");

  a_hw_watchdog: assert property (
    cpu_reset_n && !s_reg.cfg.watchdog_type_sel |-> watchdog_enable)
    else $error("hardware watchdog not enabled");

  a_src_defined: assert property (
    s_reg.state == OCD_CAPTURE && opt_byte1[5:4] == 2'h1 |=> s_reg.cfg.clock_source_sel == OCD_SRC_RC)
    else $error("reserved clock source not mapped to RC");

  a_lock_blocks: assert property (
    !opt_byte0[`OCD_B0_LOCK] && (prog_req.mode || test_mode) |=> !user_store_access_en)
    else $error("locked store left accessible in programming or test mode");

  a_unmapped_err: assert property (
    setup && !(paddr inside {`OCD_CTRL_OFFSET, `OCD_STATUS_OFFSET, `OCD_COUNT_OFFSET})
      |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped address did not answer with an error");

  a_pads_small: assert property (
    !cpu_reset_n |-> unbonded_pullup == UNBONDED44_MASK[NUM_PORTS*8-1:0])
    else $error("unbonded pads not pulled up during reset");

  // Outside reset a large package releases every pad to the port logic.
  a_pads_bonded: assert property (
    cpu_reset_n && s_reg.cfg.pkg_64pin |-> unbonded_pullup == '0)
    else $error("bonded package still forces pad pull-ups");

  // No watchdog may run while the core is held in reset.
  a_wdg_in_reset: assert property (
    !cpu_reset_n |-> !watchdog_enable)
    else $error("watchdog enabled during reset phase");

  // The doubler with the RC source is never guaranteed, so software must see the flag.
  a_pll_flag: assert property (
    cpu_reset_n && !s_reg.cfg.doubler_disable && s_reg.cfg.clock_source_sel == OCD_SRC_RC
      |-> warn_pll)
    else $error("doubler with internal RC source not flagged");

  c_locked_erase: cover property (mem_erase_req ##1 !mem_erase_req);
  c_small_pkg: cover property (cpu_run && !s_reg.cfg.pkg_64pin);
  c_halt_reset: cover property (s_reg.state == OCD_RUN ##1 s_reg.state == OCD_CAPTURE);
  c_wake: cover property (s_reg.state == OCD_WAKE ##1 s_reg.state == OCD_RUN);
  c_sw_enable: cover property (access && pwrite && paddr == `OCD_CTRL_OFFSET ##1 s_reg.watchdog_type_sel_en);

endmodule

// ### tb/ocd_prog_model.sv
// Programming tool and user memory eraser model at the far side of the decoder.
`timescale 1ns/1ns
module ocd_prog_model
  import ocd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       mem_erase_req,
  input  wire logic [7:0] prog_rdata,
  output ocd_prog_req_t   prog_req,
  output logic            mem_erase_done
);
  logic [2:0] ecnt;

  // Everything the tool drives starts idle.
  initial begin
    prog_req = '0;
    mem_erase_done = 1'b0;
    ecnt = '0;
  end

  // The eraser answers a locked erase late, so the wait is really exercised.
  always @(posedge pclk) begin
    ecnt <= mem_erase_req ? ecnt + 3'h1 : 3'h0;
    mem_erase_done <= (ecnt == 3'h3);
  end

  // One request cycle; afterwards the data lines carry the inverse, not stale data.
  task automatic drive(input logic we, input logic er, input logic a, input logic [7:0] d);
    @(posedge pclk);
    prog_req <= '{1'b1, we, a, d, er};
    @(posedge pclk);
    prog_req <= '{1'b0, 1'b0, a, ~d, 1'b0};
  endtask

  // Writes keep the reserved bit of byte 0 at its erased level.
  task automatic wr(input logic a, input logic [7:0] d);
    drive(1'b1, 1'b0, a, a ? d : (d | 8'h04));
  endtask

  // A read returns the byte one cycle after the address is presented.
  task automatic rd(input logic a, output logic [7:0] d);
    @(posedge pclk);
    prog_req <= '{1'b1, 1'b0, a, 8'h00, 1'b0};
    @(posedge pclk);
    #1 d = prog_rdata;
    @(posedge pclk);
    prog_req <= '{1'b0, 1'b0, a, 8'hFF, 1'b0};
  endtask
endmodule

// ### tb/tb.sv
// Self-checking testbench for the option byte decoder.
`timescale 1ns/1ns
module tb;
  import ocd_pkg::*;
  localparam int          LONG  = 40;
  localparam int          SHORT = 8;
  localparam logic [47:0] MASK  = 48'hFF00_F0F0_0F00;
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    ocd_src_t   src;
    logic       p64;
    int         cyc;
  } ocd_row_t;
  logic          pclk, presetn, store_init_n, psel, penable, pwrite, pready, pslverr;
  logic          test_mode, mem_erase_done, mem_erase_req, halt_enter, halt_wake;
  logic          cpu_reset_n, cpu_run, watchdog_enable, user_store_access_en, lk_n, err;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [7:0]    prog_rdata, pb;
  logic [47:0]   unbonded_pullup;
  ocd_prog_req_t prog_req;
  ocd_cfg_t      cfg, ex;
  int            n_fail = 0, cmp_count = 0, cyc_cnt = 0, n, i;
  // Row 1 locks with detectors off, a resonator, the long delay and the doubler at 2-4MHz.
  ocd_row_t rows [5] = '{'{8'hE7, 8'hEF, OCD_SRC_RC, 1'b1, SHORT},
    '{8'h3C, 8'h02, OCD_SRC_RESONATOR, 1'b0, LONG},
    '{8'h95, 8'hD5, OCD_SRC_RC, 1'b1, SHORT},
    '{8'h4F, 8'h37, OCD_SRC_EXT, 1'b1, LONG},
    '{8'hF7, 8'h61, OCD_SRC_RC, 1'b1, SHORT}};

  ocd_top #(.RST_LONG_CYC(LONG), .RST_SHORT_CYC(SHORT), .UNBONDED44_MASK(MASK)) u_dut (
    .pclk(pclk), .presetn(presetn), .store_init_n(store_init_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_req(prog_req), .test_mode(test_mode),
    .mem_erase_done(mem_erase_done), .prog_rdata(prog_rdata),
    .mem_erase_req(mem_erase_req), .halt_enter(halt_enter), .halt_wake(halt_wake),
    .cpu_reset_n(cpu_reset_n), .cpu_run(cpu_run), .cfg(cfg),
    .watchdog_enable(watchdog_enable), .user_store_access_en(user_store_access_en),
    .unbonded_pullup(unbonded_pullup));
  ocd_prog_model u_prog (.pclk(pclk), .mem_erase_req(mem_erase_req),
    .prog_rdata(prog_rdata), .prog_req(prog_req), .mem_erase_done(mem_erase_done));

  // Free-running clock; a hang is cut short by the cycle ceiling.
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // The decoded word is the option bits in place; detectors are off only at level 11.
  function automatic ocd_cfg_t exp_cfg(ocd_row_t r);
    return {r.b0[7:3], {2{r.b0[4:3] != 2'b11}}, r.b0[0], r.p64, r.b1[6], r.src,
            r.b1[3:1], r.b1[0]};
  endfunction

  // APB master: setup, then access held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts edges until reset is released or the core runs again.
  task automatic wait_hi(input int sel, output int k);
    k = 0;
    do begin
      @(posedge pclk);
      #1 k++;
    end while ((sel ? cpu_run : cpu_reset_n) !== 1'b1 && k < 200);
  endtask

  // Main sequence: power-up, then one pass per option row.
  initial begin
    {presetn, store_init_n, psel, penable, pwrite, test_mode, halt_enter, halt_wake} = '0;
    paddr = '0;
    pwdata = '0;
    lk_n = 1'b1;
    repeat (20) @(posedge pclk);
    #1 chk("cfg_in_reset", 0, cfg);
    chk("pullup_in_reset", MASK, unbonded_pullup);
    @(posedge pclk);
    store_init_n <= 1'b1;
    presetn <= 1'b1;
    wait_hi(0, n);
    chk("ship_delay", SHORT + 1, n);
    chk("ship_source", OCD_SRC_RC, cfg.clock_source_sel);
    ex = exp_cfg(rows[0]);
    for (i = 0; i < 5; i++) begin
      u_prog.drive(1'b0, 1'b1, 1'b0, 8'h00);
      #1 chk("erase_req", !lk_n, mem_erase_req);
      n = 0;
      while (mem_erase_req !== 1'b0 && n < 50) begin
        @(posedge pclk);
        #1 n++;
      end
      u_prog.rd(1'b0, pb);
      chk("erased_byte", 8'hFF, pb);
      u_prog.wr(1'b0, rows[i].b0);
      u_prog.wr(1'b1, rows[i].b1);
      u_prog.rd(1'b1, pb);
      chk("byte1_readback", rows[i].b1, pb);
      chk("cfg_held", ex, cfg);
      lk_n = rows[i].b0[0];
      ex = exp_cfg(rows[i]);
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      wait_hi(0, n);
      chk("reset_delay", rows[i].cyc + 1, n);
      chk("cfg", ex, cfg);
      chk("pullup", rows[i].p64 ? 48'h0 : MASK, unbonded_pullup);
      apb(1'b0, 12'h004, 32'h0, rd, err);
      chk("status", {1'b0, rows[i].b1[6] && rows[i].src == OCD_SRC_RESONATOR,
                     !lk_n && rows[i].b0[4:3] != 2'b11,
                     !rows[i].b1[0] && (rows[i].src == OCD_SRC_RC || rows[i].b1[3:1] != 3'h1),
                     rows[i].p64, !lk_n, 1'b1}, rd[6:0]);
      if (i % 2 == 1) apb(1'b1, 12'h000, 32'h1, rd, err);
      #1 chk("wdg_en", !rows[i].b0[6] || (i % 2 == 1), watchdog_enable);
      test_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      #1 chk("access_en", lk_n, user_store_access_en);
      test_mode <= 1'b0;
      @(posedge pclk);
      halt_enter <= 1'b1;
      @(posedge pclk);
      halt_enter <= 1'b0;
      #1 chk("halt_rst", !(rows[i].b0[7] && (!rows[i].b0[6] || i % 2 == 1)), cpu_reset_n);
      if (cpu_reset_n === 1'b1) begin
        @(posedge pclk);
        halt_wake <= 1'b1;
        @(posedge pclk);
        halt_wake <= 1'b0;
        wait_hi(1, n);
        chk("wake_delay", rows[i].cyc, n);
      end else begin
        wait_hi(0, n);
      end
    end
    apb(1'b0, 12'h00C, 32'h0, rd, err);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, rd);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk("count_idle", 0, {err, rd[15:0]});
    tally_and_finish();
  end
endmodule
